// ### see_pkg.sv
// Package of constants shared by the serial memory slave and its bus master.
// Assumes a 50 MHz system clock on both ends.
package see_pkg;
  localparam int          CLK_HZ        = 50_000_000;
  localparam logic [3:0]  DEV_TYPE_CODE = 4'h5;       // Arbitrary value
  localparam int          MEM_BYTES     = 128;
  localparam int          ADDR_W        = 7;
  localparam int          PAGE_BYTES    = 16;
  localparam int          PAGE_W        = 4;
  localparam int          TWC_US        = 1000;       // Write cycle, microseconds
  localparam int          TWC_CYCLES    = (TWC_US * (CLK_HZ / 1_000_000));
  localparam int          SCL_HALF_DIV  = 125;        // Tick divider; 3 ticks per bus clock, about 133 kHz
  localparam logic        DIR_READ      = 1'b1;
  localparam logic        DIR_WRITE     = 1'b0;
  localparam logic [7:0]  MEM_RESET     = 8'h00;
endpackage : see_pkg

// ### see_bus_if.sv
// Two-wire bus between the memory slave and its master.
// The interface resolves the open-drain wires from the pull-down enables.
`timescale 1ns/1ps
interface see_bus_if;
  logic scl_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = ~scl_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport slave  (input scl, input sda, output sda_s_oe);
  modport master (input scl, input sda, output scl_oe, output sda_m_oe);
endinterface : see_bus_if

// ### see_slave.sv
// Serial memory slave: 128 bytes, 16-byte page buffer, self-timed write.
// Assumes bus wires arrive asynchronously; sampled by the system clock.
// Notes on behaviour
// R1: SDA fall while SCL high is Start
// R2: SDA rise while SCL high is Stop
// R3: Bus idle when both lines high
// R4: Bit sampled on clock high, changed low
// R5: Master gives ninth clock for acknowledge
// R6: Acknowledger holds SDA low through clock high
// R7: No acknowledge during internal write cycle
// R8: Master nack ends read, slave releases SDA
// R9: Control byte: type code, three select bits
// R10: Last control bit: 1 read, 0 write
// R11: Byte write: address, data, commit on Stop
// R12: Up to sixteen bytes buffered per page
// R13: Write pointer increments low four bits
// R14: Master avoids crossing page boundaries; tb writes three bytes from address 0e, the third wrapping to 00
// R15: Master polls with write control byte
// R16: Current read serves last address plus one
// R17: Address write then repeated Start sets pointer
// R18: Master ack continues, nack stops sending
// R19: Read pointer wraps whole array
// R20: No transfer continues across devices
// R21: Write cycle finishes within write time
// R22: Released unless addressed; Start/Stop restarts
// R23: SDA only pulled low, never driven high
`timescale 1ns/1ps
module see_slave
  import see_pkg::*;
#(
  parameter int TWC = TWC_CYCLES
) (
  // System
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_ARST_N,
  // Chip select straps
  input  wire logic [2:0]  I_CHIP_SELECT,
  // Bus
  see_bus_if.slave         bus,
  // Status
  output logic             O_WRITE_BUSY
);
  // Refuse a write time the counter cannot time
  if (TWC < 1) begin : g_bad_twc
    $error("write time too short");
  end

  typedef enum logic [2:0] {
    SEE_IDLE = 3'b000, SEE_CTRL = 3'b001, SEE_ADDR = 3'b010,
    SEE_WDATA = 3'b011, SEE_RDATA = 3'b100, SEE_RACK = 3'b101
  } see_state_t;

  logic [1:0]        scl_sy;
  logic [1:0]        sda_sy;
  logic              scl_d;
  logic              sda_d;
  logic [7:0]        mem [MEM_BYTES];
  logic [7:0]        page [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld;
  logic [ADDR_W-1:0] ptr;
  logic [ADDR_W-1:0] wr_base;
  see_state_t        state;
  logic [3:0]        bit_cnt;
  logic [7:0]        shreg;
  logic              ack_slot;
  logic              drive_low;
  logic              wr_pend;
  logic [31:0]       twc_cnt;
  logic              busy;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;

  // Two-stage synchronisers; the second stage and its delayed copy feed logic
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      scl_sy <= 2'b11;
      sda_sy <= 2'b11;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], bus.scl};
      sda_sy <= {sda_sy[0], bus.sda};
      scl_d  <= scl_sy[1];
      sda_d  <= sda_sy[1];
    end
  end

  assign scl_rise = scl_sy[1] & ~scl_d; // R4
  assign scl_fall = ~scl_sy[1] & scl_d;
  assign start_c  = scl_sy[1] & scl_d & sda_d & ~sda_sy[1]; // R1
  assign stop_c   = scl_sy[1] & scl_d & ~sda_d & sda_sy[1]; // R2 R3

  // Byte engine
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state     <= SEE_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      ack_slot  <= 1'b0;
      drive_low <= 1'b0;
      ptr       <= '0;
      wr_base   <= '0;
      page_vld  <= '0;
      wr_pend   <= 1'b0;
    end else if (start_c) begin
      state     <= SEE_CTRL; // R22 R17
      bit_cnt   <= 4'h0;
      ack_slot  <= 1'b0;
      drive_low <= 1'b0;
      page_vld  <= '0;
    end else if (stop_c) begin
      state     <= SEE_IDLE; // R22
      drive_low <= 1'b0;
      ack_slot  <= 1'b0;
      if (|page_vld) begin
        wr_pend <= 1'b1; // R11 R12
      end
    end else begin
      if (wr_pend && !busy) begin
        wr_pend  <= 1'b0;
        page_vld <= '0;
      end
      if (state != SEE_IDLE && scl_rise && !ack_slot) begin
        shreg   <= {shreg[6:0], sda_d};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (state == SEE_RACK && scl_rise && ack_slot) begin
        if (sda_d) begin
          state <= SEE_IDLE; // R8 R18
        end else begin
          state <= SEE_RDATA; // R18
        end
      end
      if (scl_fall) begin
        drive_low <= 1'b0;
        if (ack_slot) begin
          ack_slot <= 1'b0;
          bit_cnt  <= 4'h0;
          if (state == SEE_RDATA) begin
            shreg     <= mem[ptr];
            drive_low <= ~mem[ptr][7];
          end
        end else if (bit_cnt == 4'd8) begin
          ack_slot <= 1'b1;
          case (state)
            SEE_CTRL: begin
              if (!busy && !wr_pend && shreg[7:4] == DEV_TYPE_CODE
                  && shreg[3:1] == I_CHIP_SELECT) begin // R7 R9
                drive_low <= 1'b1; // R6
                state     <= (shreg[0] == DIR_READ) ? SEE_RDATA : SEE_ADDR; // R10 R16
              end else begin
                state <= SEE_IDLE; // R22
              end
            end
            SEE_ADDR: begin
              ptr       <= shreg[ADDR_W-1:0]; // R11 R17
              wr_base   <= shreg[ADDR_W-1:0];
              drive_low <= 1'b1;
              state     <= SEE_WDATA;
            end
            SEE_WDATA: begin
              page[ptr[PAGE_W-1:0]]     <= shreg; // R12
              page_vld[ptr[PAGE_W-1:0]] <= 1'b1;
              ptr <= {ptr[ADDR_W-1:PAGE_W], ptr[PAGE_W-1:0] + 4'h1}; // R13
              drive_low <= 1'b1;
            end
            SEE_RDATA: begin
              ptr   <= ptr + 7'h01; // R19 R20
              state <= SEE_RACK;
            end
            default: begin
              state <= SEE_IDLE;
            end
          endcase
        end else if (state == SEE_RDATA && bit_cnt != 4'h0) begin
          drive_low <= ~shreg[7];
        end
      end
    end
  end

  // First read bit goes out on the ack clock fall; later bits on the following falls

  // Self-timed commit of buffered page
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      busy    <= 1'b0;
      twc_cnt <= 32'h0000_0000;
    end else if (busy) begin
      if (twc_cnt == 32'(TWC - 1)) begin
        busy <= 1'b0; // R21
      end
      twc_cnt <= twc_cnt + 32'h0000_0001;
    end else if (wr_pend) begin
      busy    <= 1'b1; // R7
      twc_cnt <= 32'h0000_0000;
    end
  end

  // Commit on the edge that starts the cycle, while the valid bits still stand
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int j = 0; j < MEM_BYTES; j++) begin
        mem[j] <= MEM_RESET;
      end
    end else if (wr_pend && !busy) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_vld[i]) begin
          mem[{wr_base[ADDR_W-1:PAGE_W], 4'(i)}] <= page[i]; // R13
        end
      end
    end
  end

  assign bus.sda_s_oe = drive_low; // R23
  assign O_WRITE_BUSY = busy | wr_pend;
endmodule : see_slave

// ### see_master.sv
// Bus master that runs write and read commands on the two-wire bus.
// Assumes a single user request at a time; bus clock divided from I_CLK_SYS.
`timescale 1ns/1ps
module see_master
  import see_pkg::*;
(
  // System
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_ARST_N,
  // Request
  input  wire logic        I_REQ,
  input  wire logic        I_START,
  input  wire logic        I_STOP,
  input  wire logic        I_READ,
  input  wire logic        I_NACK,
  input  wire logic [7:0]  I_WDATA,
  // Answer
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic [7:0]       O_RDATA,
  output logic             O_ACKED,
  // Bus
  see_bus_if.master        bus
);
  typedef enum logic [2:0] {
    SEM_IDLE = 3'b000, SEM_START = 3'b001, SEM_BIT = 3'b010,
    SEM_STOP = 3'b011, SEM_DONE = 3'b100
  } sem_state_t;

  sem_state_t  state;
  logic [7:0]  div;
  logic        tick;
  logic [1:0]  phase;
  logic [3:0]  bit_cnt;
  logic [8:0]  sh;
  logic        rd;
  logic        do_stop;
  logic [1:0]  sda_sy;
  logic        scl_oe;
  logic        sda_oe;

  assign tick = (div == 8'(SCL_HALF_DIV - 1));

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      div <= 8'h00;
    end else begin
      div <= tick ? 8'h00 : div + 8'h01;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sda_sy <= 2'b11;
    end else begin
      sda_sy <= {sda_sy[0], bus.sda};
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state   <= SEM_IDLE;
      phase   <= 2'b00;
      bit_cnt <= 4'h0;
      sh      <= 9'h1FF;
      rd      <= 1'b0;
      do_stop <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      O_RDATA <= 8'h00;
      O_ACKED <= 1'b0;
      O_DONE  <= 1'b0;
    end else begin
      O_DONE <= 1'b0;
      case (state)
        SEM_IDLE: begin
          if (I_REQ) begin
            rd      <= I_READ;
            do_stop <= I_STOP;
            sh      <= I_READ ? {8'hFF, I_NACK} : {I_WDATA, 1'b1};
            bit_cnt <= 4'h0;
            phase   <= 2'b00;
            state   <= I_START ? SEM_START : SEM_BIT;
          end
        end
        SEM_START: if (tick) begin // R1
          phase <= phase + 2'b01;
          case (phase)
            2'b00: begin sda_oe <= 1'b0; scl_oe <= 1'b0; end
            2'b01: sda_oe <= 1'b1;
            2'b10: begin scl_oe <= 1'b1; phase <= 2'b00; state <= SEM_BIT; end
            default: phase <= 2'b00;
          endcase
        end
        SEM_BIT: if (tick) begin // R4 R5
          phase <= phase + 2'b01;
          case (phase)
            2'b00: sda_oe <= ~sh[8];
            2'b01: scl_oe <= 1'b0;
            2'b10: begin
              sh <= {sh[7:0], sda_sy[1]};
              scl_oe <= 1'b1;
              phase <= 2'b00;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'd8) begin
                O_ACKED <= ~sda_sy[1];
                O_RDATA <= sh[7:0];
                sda_oe  <= 1'b0;
                state   <= do_stop ? SEM_STOP : SEM_DONE;
              end
            end
            default: phase <= 2'b00;
          endcase
        end
        SEM_STOP: if (tick) begin // R2 R8
          phase <= phase + 2'b01;
          case (phase)
            2'b00: sda_oe <= 1'b1;
            2'b01: scl_oe <= 1'b0;
            2'b10: begin sda_oe <= 1'b0; phase <= 2'b00; state <= SEM_DONE; end
            default: phase <= 2'b00;
          endcase
        end
        default: begin
          O_DONE <= 1'b1;
          state  <= SEM_IDLE;
        end
      endcase
    end
  end

  assign bus.scl_oe   = scl_oe;
  assign bus.sda_m_oe = sda_oe;
  assign O_BUSY       = (state != SEM_IDLE);
endmodule : see_master

// ### see_props.sv
// Checker for the two-wire bus between the memory slave and its master.
// Instantiated in tb beside the bus; sees wire levels, enables and busy.
`timescale 1ns/1ps
module see_props #(
  parameter int TWC = 200
) (
  // System
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  input wire logic O_WRITE_BUSY,
  // Bus
  input wire logic scl_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int TWC_MAX = TWC + 16;
  logic idle;
  int   busy_cnt;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_ARST_N);
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) idle <= 1'b1;
    else if (scl && $rose(sda)) idle <= 1'b1;
    else if (scl && $fell(sda)) idle <= 1'b0;
  end
  // Counts the pending plus self-timed span; too long for a delay range
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) busy_cnt <= 0;
    else if (!O_WRITE_BUSY) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  a_start_opens_frame: assert property ($fell(scl) |-> !idle)
    else $error("bus clock ran outside a frame");
  a_stop_frees_bus: assert property (scl && $rose(sda) |-> (scl && sda) [*8])
    else $error("bus not idle after stop");
  a_data_setup_ok: assert property ($rose(scl) |-> $stable(sda_m_oe) && $stable(sda_s_oe))
    else $error("data changed at clock rise");
  a_slave_data_hold: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave changed data with clock high");
  a_ack_held_low: assert property ($rose(scl) && sda_s_oe |-> sda_s_oe throughout (##[1:400] !scl))
    else $error("slave ack not held through clock high");
  a_no_ack_cycling: assert property (O_WRITE_BUSY |-> !sda_s_oe)
    else $error("slave drove data during write cycle");
  a_write_cycle_bound: assert property (busy_cnt <= TWC_MAX)
    else $error("write cycle too long");
  a_release_on_start: assert property (scl && $fell(sda) |=> !sda_s_oe [*8])
    else $error("slave drove data right after start");
  a_pull_low_only: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("slave began pulling data with clock high");
endmodule // see_props

// ### tb.sv
// Testbench: memory slave and bus master joined by the bus, checker beside.
// Assumes the request and done contract of the master and a write time a tenth of TWC_CYCLES.
`timescale 1ns/1ps
module tb
  import see_pkg::*;
;
  typedef struct packed {
    logic [3:0] fl;
    logic [7:0] wd;
    logic [1:0] ak;
    logic [7:0] rv;
    logic       ckr;
  } see_row_t;
  localparam logic [2:0] CS  = 3'h5;
  localparam logic [7:0] CW  = {DEV_TYPE_CODE, CS, DIR_WRITE};
  localparam logic [7:0] CR  = {DEV_TYPE_CODE, CS, DIR_READ};
  localparam int         TWC = 5000;
  // Flags: start, stop, read, nack; ak: expected ack, ack checked
  localparam see_row_t ROWS [18] = '{
    {4'hc, {DEV_TYPE_CODE, 3'h2, DIR_WRITE}, 2'h1, 8'h00, 1'h0},
    {4'hc, {DEV_TYPE_CODE ^ 4'h1, CS, DIR_WRITE}, 2'h1, 8'h00, 1'h0},
    {4'h8, CW, 2'h3, 8'h00, 1'h0}, {4'h0, 8'h0e, 2'h3, 8'h00, 1'h0},
    {4'h0, 8'h3c, 2'h3, 8'h00, 1'h0}, {4'h0, 8'h5a, 2'h3, 8'h00, 1'h0},
    {4'h4, 8'h96, 2'h3, 8'h00, 1'h0},
    {4'h8, CW, 2'h3, 8'h00, 1'h0}, {4'h0, 8'h0e, 2'h3, 8'h00, 1'h0},
    {4'h8, CR, 2'h3, 8'h00, 1'h0}, {4'h7, 8'h00, 2'h0, 8'h3c, 1'h1},
    {4'h8, CR, 2'h3, 8'h00, 1'h0}, {4'h7, 8'h00, 2'h0, 8'h5a, 1'h1},
    {4'h8, CW, 2'h3, 8'h00, 1'h0}, {4'h0, 8'h7f, 2'h3, 8'h00, 1'h0},
    {4'h8, CR, 2'h3, 8'h00, 1'h0}, {4'h2, 8'h00, 2'h0, MEM_RESET, 1'h1},
    {4'h7, 8'h00, 2'h0, 8'h96, 1'h1}};
  logic       clk;
  logic       arst_n;
  logic       req;
  logic [3:0] fl;
  logic [7:0] wdata;
  logic       busy;
  logic       done;
  logic [7:0] rdata;
  logic       acked;
  logic       write_busy;
  int         num_errors;
  int         total_checks;
  int         n;
  see_bus_if see_bus_if_inst ();
  see_slave #(.TWC(TWC)) see_slave_inst (.I_CLK_SYS(clk), .I_ARST_N(arst_n),
    .I_CHIP_SELECT(CS), .bus(see_bus_if_inst), .O_WRITE_BUSY(write_busy));
  see_master see_master_inst (.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_REQ(req),
    .I_START(fl[3]), .I_STOP(fl[2]), .I_READ(fl[1]), .I_NACK(fl[0]), .I_WDATA(wdata),
    .O_BUSY(busy), .O_DONE(done), .O_RDATA(rdata), .O_ACKED(acked), .bus(see_bus_if_inst));
  see_props #(.TWC(TWC)) see_props_inst (.I_CLK_SYS(clk), .I_ARST_N(arst_n),
    .O_WRITE_BUSY(write_busy), .scl_oe(see_bus_if_inst.scl_oe),
    .sda_m_oe(see_bus_if_inst.sda_m_oe), .sda_s_oe(see_bus_if_inst.sda_s_oe),
    .scl(see_bus_if_inst.scl), .sda(see_bus_if_inst.sda));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One byte; the request stands for exactly one sampled edge
  task automatic xfer(input see_row_t r);
    int k;
    @(posedge clk);
    {req, fl, wdata} <= {1'b1, r.fl, r.wd};
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 6000);
    if (k >= 6000) chk("done", 8'h00, 8'h01);
  endtask
  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      xfer(ROWS[i]);
      if (ROWS[i].ak[0]) chk("acked", {7'h00, acked}, {7'h00, ROWS[i].ak[1]});
      if (ROWS[i].ckr) chk("rdata", rdata, ROWS[i].rv);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (95000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {req, fl, wdata} = '0;
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    run_rows(0, 6);
    $display("test select_and_page_write done");
    // Poll while the page commits: refused until the cycle ends
    xfer({4'hc, CW, 2'h0, 8'h00, 1'h0});
    chk("poll_ack", {7'h00, acked}, 8'h00);
    chk("write_busy", {7'h00, write_busy}, 8'h01);
    n = 0;
    while (write_busy !== 1'b0 && n < TWC + 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy_end", {7'h00, write_busy}, 8'h00);
    $display("test ack_polling done");
    run_rows(7, 17);
    $display("test reads done");
    // Reset in the middle of a control byte
    @(posedge clk);
    {req, fl, wdata} <= {1'b1, 4'h8, CW};
    @(posedge clk);
    req <= 1'b0;
    repeat (1000) @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset", {3'h0, busy, done, write_busy, see_bus_if_inst.sda_s_oe,
      see_bus_if_inst.scl_oe}, 8'h00);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    xfer({4'hc, CW, 2'h3, 8'h00, 1'h0});
    chk("restart_ack", {7'h00, acked}, 8'h01);
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule // tb
